// file: hw/fsr_ctrl.sv
// The address-and-strobe port and the address map were chosen for this implementation.
module fsr_ctrl
  import fsr_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // software port
  input  wire logic [3:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [15:0]       rdata,
  output wire logic              irq,
  // drive interface, active low
  output wire logic              select_n,
  output wire logic              motor_on_n,
  output wire logic              write_gate_n,
  output wire logic              write_data_n,
  output wire logic              side_n,
  input  wire logic              protect_n,
  input  wire logic              read_data_n,
  // write data source
  input  wire logic              wr_pulse,
  // recovered flux edges
  output logic                   flux_edge
);
  if (CNT_W < 8 || CNT_W > 16)
  begin : g_cnt_w_check
    $error("CNT_W out of range");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [7:0]       ctrl;
  logic [2:0]       irq_stat;
  logic [2:0]       irq_mask;
  logic [CNT_W-1:0] pulse_cnt;
  logic [7:0]       low_cnt;

  wire wr_ctrl = wr && addr == FSR_ADDR_CTRL;
  wire wr_irq  = wr && addr == FSR_ADDR_IRQ;
  wire wr_mask = wr && addr == FSR_ADDR_MASK;
  wire wr_cnt  = wr && addr == FSR_ADDR_COUNT;

  wire want_sel   = ctrl[FSR_CTRL_SELECT];
  wire want_write = ctrl[FSR_CTRL_WRITE];
  wire protected_now = want_sel && !protect_n;
  // gate only opens on an unprotected, selected drive
  wire writing = want_sel && want_write && !protected_now;
  wire reading = want_sel && !writing;
  wire refuse  = wr_ctrl && wdata[FSR_CTRL_WRITE] && wdata[FSR_CTRL_SELECT]
                 && !protect_n;

  assign select_n     = ~want_sel;
  assign motor_on_n   = ~ctrl[FSR_CTRL_MOTOR];
  assign write_gate_n = ~writing;
  assign side_n       = ~ctrl[FSR_CTRL_SIDE];
  // idle write line whenever the gate is off
  assign write_data_n = ~(writing && wr_pulse);

  // ----------------------------------------------------------------
  // read pulse capture
  // ----------------------------------------------------------------
  logic fall;

  fsr_edge fsr_edge_inst
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .line_n  (read_data_n),
    .fall    (fall)
  );

  // leading edge is the timing point, so the strobe fires on it
  wire take = fall && reading;
  // a low that lasts twice the pulse width hints a stuck line
  wire too_long = !read_data_n && reading
                  && low_cnt == 8'(FSR_READ_PULSE_CY * 2);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      ctrl <= FSR_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= wdata[7:0];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flux_edge <= 1'b0;
      low_cnt   <= 8'h00;
    end
    else
    begin
      flux_edge <= take;
      if (read_data_n)
        low_cnt <= 8'h00;
      else if (low_cnt != 8'hff)
        low_cnt <= low_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pulse_cnt <= '0;
    else if (take)
      pulse_cnt <= pulse_cnt + CNT_W'(1);
    else if (wr_cnt)
      pulse_cnt <= '0;
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  wire [2:0] irq_set = {too_long, refuse, take};
  wire [2:0] irq_clr = wr_irq ? wdata[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end
    else
    begin
      // set beats clear in the same cycle
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_mask)
        irq_mask <= wdata[2:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  wire [15:0] stat_word = {13'h0000, reading, writing, protected_now};
  wire [15:0] cnt_word  = 16'(pulse_cnt);
  wire [15:0] rd_mux =
    addr == FSR_ADDR_CTRL  ? {8'h00, ctrl} :
    addr == FSR_ADDR_STAT  ? stat_word :
    addr == FSR_ADDR_IRQ   ? {13'h0000, irq_stat} :
    addr == FSR_ADDR_MASK  ? {13'h0000, irq_mask} :
    addr == FSR_ADDR_COUNT ? cnt_word : 16'h0000;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 16'h0000;
    else
      rdata <= rd ? rd_mux : 16'h0000;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_gate_protect;
    @(posedge clk_sys) disable iff (!reset_n)
    !protect_n && !select_n |-> write_gate_n;
  endproperty
  a_gate_protect: assert property (p_gate_protect)
    else $error("write gate open on protected disk");

  property p_data_idle;
    @(posedge clk_sys) disable iff (!reset_n)
    write_gate_n |-> write_data_n;
  endproperty
  a_data_idle: assert property (p_data_idle)
    else $error("write data active with gate off");

  property p_read_state;
    @(posedge clk_sys) disable iff (!reset_n)
    flux_edge |-> $past(!select_n) && $past(write_gate_n);
  endproperty
  a_read_state: assert property (p_read_state)
    else $error("flux edge outside read state");

  property p_edge_lead;
    @(posedge clk_sys) disable iff (!reset_n)
    $fell(read_data_n) && !select_n && write_gate_n |=> flux_edge;
  endproperty
  a_edge_lead: assert property (p_edge_lead)
    else $error("leading edge not reported");

  property p_motor;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_ctrl |=> motor_on_n == !$past(wdata[FSR_CTRL_MOTOR]);
  endproperty
  a_motor: assert property (p_motor)
    else $error("motor line does not follow control");

  property p_refuse_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    refuse |=> irq_stat[FSR_IRQ_REFUSED];
  endproperty
  a_refuse_flag: assert property (p_refuse_flag)
    else $error("refused write not flagged");

  property p_edge_once;
    @(posedge clk_sys) disable iff (!reset_n)
    flux_edge |=> !flux_edge;
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("flux edge held over two cycles");
endmodule // fsr_ctrl

// file: hw/fsr_pkg.sv
package fsr_pkg;
  // ----------------------------------------------------------------
  // register map of the controller
  // ----------------------------------------------------------------
  localparam logic [3:0] FSR_ADDR_CTRL  = 4'h0;
  localparam logic [3:0] FSR_ADDR_STAT  = 4'h1;
  localparam logic [3:0] FSR_ADDR_IRQ   = 4'h2;
  localparam logic [3:0] FSR_ADDR_MASK  = 4'h3;
  localparam logic [3:0] FSR_ADDR_COUNT = 4'h4;

  // ctrl fields
  localparam int FSR_CTRL_SELECT = 0;
  localparam int FSR_CTRL_MOTOR  = 1;
  localparam int FSR_CTRL_WRITE  = 2;
  localparam int FSR_CTRL_SIDE   = 3;
  localparam logic [7:0] FSR_CTRL_RESET = 8'h00;

  // status / irq fields
  localparam int FSR_ST_PROTECT  = 0;
  localparam int FSR_ST_WRITING  = 1;
  localparam int FSR_ST_READING  = 2;
  localparam int FSR_IRQ_PULSE   = 0;
  localparam int FSR_IRQ_REFUSED = 1;
  localparam int FSR_IRQ_WIDTH   = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FSR_CLK_HZ        = 10_000_000;
  localparam int FSR_CLK_NS        = 1_000_000_000 / FSR_CLK_HZ;
  localparam int FSR_READ_PULSE_NS = 1_000;
  localparam int FSR_READ_PULSE_CY =
    (FSR_READ_PULSE_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
endpackage : fsr_pkg

// file: hw/fsr_edge.sv
// falling-edge detector for an active-low line from the drive
module fsr_edge
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // line
  input  wire logic line_n,
  output wire logic fall
);
  logic prev_n;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prev_n <= 1'b1;
    else
      prev_n <= line_n;
  end

  assign fall = prev_n & ~line_n;
endmodule // fsr_edge

// file: sim/fsr_drive_model.sv
// behavioural drive: protect switch, read one-shot, write flux counter
module fsr_drive_model
(
  // from the controller
  input  wire logic select_n,
  input  wire logic motor_on_n,
  input  wire logic write_gate_n,
  input  wire logic write_data_n,
  // bench commands
  input  wire logic wp,
  input  wire logic flux,
  // to the controller and the bench
  output wire logic protect_n,
  output wire logic read_data_n,
  output wire logic spinning,
  output int        wr_flux
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pulse = 1'b0;
  wire  logic sel = ~select_n;
  wire  logic wr_act = sel & ~write_gate_n & ~wp;
  assign protect_n = ~(sel & wp);
  assign spinning = ~motor_on_n;
  // pull-up on the line: released means high
  assign read_data_n = ~(pulse & sel);
  initial wr_flux = 0;
  always @(negedge write_data_n)
    if (wr_act)
      wr_flux++;
  // a second event inside the one-shot is dropped like a runt
  always @(posedge flux)
    if (sel && write_gate_n && !pulse)
    begin
      pulse = 1'b1;
      #1000 pulse = 1'b0;
    end
endmodule // fsr_drive_model

// file: sim/fsr_ctrl_test.sv
module fsr_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fsr_pkg::*;
  logic        clk_sys = 0, reset_n = 0, wr = 0, rd = 0;
  logic        wr_pulse = 0, wp = 0, flux = 0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, d;
  logic [15:0] rdata;
  wire  logic  irq, select_n, motor_on_n, write_gate_n, write_data_n;
  wire  logic  side_n, protect_n, read_data_n, spinning, flux_edge;
  int          err_total = 0, cmp_count = 0, wr_flux;

  fsr_ctrl #(.CNT_W(16)) fsr_ctrl_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .select_n(select_n), .motor_on_n(motor_on_n),
    .write_gate_n(write_gate_n), .write_data_n(write_data_n),
    .side_n(side_n), .protect_n(protect_n), .read_data_n(read_data_n),
    .wr_pulse(wr_pulse), .flux_edge(flux_edge));
  fsr_drive_model fsr_drive_model_inst (.select_n(select_n),
    .motor_on_n(motor_on_n), .write_gate_n(write_gate_n),
    .write_data_n(write_data_n), .wp(wp), .flux(flux),
    .protect_n(protect_n), .read_data_n(read_data_n),
    .spinning(spinning), .wr_flux(wr_flux));

  initial forever #50 clk_sys = ~clk_sys;

  task automatic chk(input string n, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys) {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk_sys) wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk_sys) {rd, addr} <= {1'b1, a};
    @(posedge clk_sys) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // one flux event, then room for the 1 us pulse to finish
  task automatic fluxp(input logic e);
    @(posedge clk_sys) flux <= 1'b1;
    @(posedge clk_sys) flux <= 1'b0;
    #1 chk("edge", flux_edge, e);
    cyc(14);
  endtask
  task automatic wpulse;
    @(posedge clk_sys) wr_pulse <= 1'b1;
    @(posedge clk_sys) wr_pulse <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rreg(FSR_ADDR_CTRL);
    chk("ctrl", d, 16'h0000);
    chk("lines", {select_n, motor_on_n, write_gate_n, side_n}, 16'h000f);
    chk("irq", irq, 16'h0000);
  endtask
  task automatic t_read;
    wreg(FSR_ADDR_CTRL, 16'h000b);
    wreg(FSR_ADDR_MASK, 16'h0001);
    wreg(FSR_ADDR_COUNT, 16'h0000);
    chk("motor", {spinning, select_n, side_n}, 16'h0004);
    chk("protect", protect_n, 16'h0001);
    repeat (3) fluxp(1'b1);
    rreg(FSR_ADDR_COUNT);
    chk("count", d, 16'h0003);
    chk("irq", irq, 16'h0001);
    wreg(FSR_ADDR_IRQ, 16'h0001);
    cyc(1);
    chk("irq", irq, 16'h0000);
  endtask
  task automatic t_unsel;
    wreg(FSR_ADDR_CTRL, 16'h0002);
    wp <= 1'b1;
    fluxp(1'b0);
    chk("protect", protect_n, 16'h0001);
    rreg(FSR_ADDR_COUNT);
    chk("count", d, 16'h0003);
    wp <= 1'b0;
  endtask
  task automatic t_write;
    wreg(FSR_ADDR_CTRL, 16'h0007);
    chk("gate", write_gate_n, 16'h0000);
    wpulse();
    wpulse();
    chk("wflux", wr_flux, 16'h0002);
    fluxp(1'b0);
    rreg(FSR_ADDR_COUNT);
    chk("count", d, 16'h0003);
    wreg(FSR_ADDR_CTRL, 16'h0003);
    @(posedge clk_sys) wr_pulse <= 1'b1;
    #1 chk("wdata", write_data_n, 16'h0001);
    @(posedge clk_sys) wr_pulse <= 1'b0;
  endtask
  task automatic t_protect;
    wreg(FSR_ADDR_CTRL, 16'h0007);
    @(posedge clk_sys) wp <= 1'b1;
    cyc(2);
    chk("protect", protect_n, 16'h0000);
    chk("gate", write_gate_n, 16'h0001);
    wreg(FSR_ADDR_MASK, 16'h0002);
    wreg(FSR_ADDR_CTRL, 16'h0007);
    wpulse();
    chk("wflux", wr_flux, 16'h0002);
    rreg(FSR_ADDR_STAT);
    chk("stat", d & 16'h0003, 16'h0001);
    cyc(1);
    chk("irq", irq, 16'h0001);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #3_000_000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    t_reset();
    t_read();
    t_unsel();
    t_write();
    t_protect();
    end_of_test();
  end
endmodule // fsr_ctrl_test
